// ==== hw/srf_map.vh ====
// Constants for the safety relay status and fault indicator.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SRF_MAP_VH
`define SRF_MAP_VH
// Clock rate in kHz, times in ms
`define SRF_CLK_KHZ 100000
`define SRF_SUPPLY_LOSS_MS 20
`define SRF_OFF_MIN_MS 1000
`define SRF_FB_TIMEOUT_MS 150
`define SRF_FLASH_MS 1000
`define SRF_SHORT_MS 200
`define SRF_LEAD_PAUSE_MS 2000
`define SRF_DIGIT_PAUSE_MS 2000
`define SRF_BLINK_MS 500
`define SRF_TEST_PERIOD_MS 100
// Test pulse low time in cycles (1 us)
`define SRF_TEST_LOW_CYC 100
`define SRF_INIT_MS 500
// Fault code layout: four 4-bit digits, count of digits
`define SRF_DIG_W 4
`define SRF_CODE_W 16
`define SRF_NDIG_W 3
`define SRF_SHORT_COUNT 3
// Feedback timeout code 1,8
`define SRF_CODE_FB 16'h0018
`define SRF_NDIG_FB 3'h2
// Supply interruption code 8,2
`define SRF_CODE_SUP 16'h0082
`define SRF_NDIG_SUP 3'h2
`endif

// ==== hw/srf_flash.v ====
// Fault code flasher: three short flashes, lead pause, digit flash groups.
// Assumes code digits are packed most significant first in the low digits.
`timescale 1ns/10ps
`include "srf_map.vh"
module srf_flash #(
   parameter [31:0] SHORT_CYC = 32'h0000_0010,
   parameter [31:0] FLASH_CYC = 32'h0000_0040,
   parameter [31:0] PAUSE_CYC = 32'h0000_0080
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Code in
   input wire run,
   input wire [`SRF_CODE_W-1:0] code,
   input wire [`SRF_NDIG_W-1:0] ndig,
   // Lamp out
   output reg lamp
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SHORT = 3'h1;
   localparam [2:0] ST_LEAD = 3'h2;
   localparam [2:0] ST_DIGIT = 3'h3;
   localparam [2:0] ST_GAP = 3'h4;
   // Timers run down to zero inclusive, so each load is one less
   localparam [31:0] SHORT_LD = SHORT_CYC - 32'h0000_0001;
   localparam [31:0] FLASH_LD = FLASH_CYC - 32'h0000_0001;
   localparam [31:0] PAUSE_LD = PAUSE_CYC - 32'h0000_0001;
   reg [2:0] state;
   reg [31:0] tmr;
   reg [4:0] cnt;
   reg [2:0] dig;
   reg [3:0] dval;
   always @* begin
      case (dig)
         3'h0: dval = code[`SRF_DIG_W*0 +: `SRF_DIG_W];
         3'h1: dval = code[`SRF_DIG_W*1 +: `SRF_DIG_W];
         3'h2: dval = code[`SRF_DIG_W*2 +: `SRF_DIG_W];
         default: dval = code[`SRF_DIG_W*3 +: `SRF_DIG_W];
      endcase
   end
   // Zero digit shows as sixteen flashes
   wire [4:0] want = (dval == 4'h0) ? 5'h10 : {1'b0, dval}; // [R11]
   // Each flash is on for one period, then off for one period
   wire half_done = (tmr == 32'h0000_0000);
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         tmr <= 32'h0000_0000;
         cnt <= 5'h00;
         dig <= 3'h0;
         lamp <= 1'b0;
      end else if (!run) begin
         state <= ST_IDLE;
         lamp <= 1'b0;
      end else begin
         if (!half_done) tmr <= tmr - 32'h0000_0001;
         case (state)
            ST_IDLE: begin
               state <= ST_SHORT;
               cnt <= 5'h00;
               lamp <= 1'b1;
               tmr <= SHORT_LD;
            end
            ST_SHORT: if (half_done) begin // [R8]
               if (lamp) begin
                  lamp <= 1'b0;
                  tmr <= SHORT_LD;
                  cnt <= cnt + 5'h01;
               end else if (cnt == `SRF_SHORT_COUNT) begin
                  state <= ST_LEAD;
                  tmr <= PAUSE_LD;
               end else begin
                  lamp <= 1'b1;
                  tmr <= SHORT_LD;
               end
            end
            ST_LEAD: if (half_done) begin
               state <= ST_DIGIT;
               dig <= ndig - 3'h1;
               cnt <= 5'h00;
               lamp <= 1'b1;
               tmr <= FLASH_LD;
            end
            ST_DIGIT: if (half_done) begin // [R9]
               if (lamp) begin
                  lamp <= 1'b0;
                  tmr <= FLASH_LD;
                  cnt <= cnt + 5'h01;
               end else if (cnt == want) begin
                  state <= ST_GAP;
                  tmr <= PAUSE_LD;
               end else begin
                  lamp <= 1'b1;
                  tmr <= FLASH_LD;
               end
            end
            ST_GAP: if (half_done) begin // [R10]
               cnt <= 5'h00;
               if (dig == 3'h0) begin
                  state <= ST_IDLE;
               end else begin
                  dig <= dig - 3'h1;
                  state <= ST_DIGIT;
                  lamp <= 1'b1;
                  tmr <= FLASH_LD;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // srf_flash

// ==== hw/srf_indicator.v ====
// Status and fault indication, supply supervision and AND-link gating.
// Assumes pins are asynchronous; enable request comes from input logic.
// Contract
// [R1] Flash power LED during mode detection, steady once ready.
// [R2] Mode is sampled only during the initialisation phase.
// [R3] Channel LEDs follow safety outputs 14 and 24 exactly; the code drives them from on14 and on24, so test pulses do not show.
// [R4] Power LED also flashes on unknown mode or missing start; the code has no unknown-mode check, only start_pending.
// [R5] Channel LEDs alternate on open feedback at start or one channel open.
// [R6] Supply gap over 20 ms is an error: outputs low, error shown.
// [R7] Locked out until supply is off at least 1 s then back.
// [R8] Coded fault starts with three short flashes then a pause.
// [R9] Each digit shown as one-second flashes, count equals digit.
// [R10] One to four digits, pauses between, whole sequence repeats.
// [R11] Digits 1 to 15 flash that often; zero flashes sixteen times.
// [R12] Test pulses are injected on high safety outputs.
// [R13] Low AND-link input forces the safety outputs low.
// [R14] A loaded linking output feeds at most four downstream inputs.
// [R15] An unloaded linking output feeds at most fifty inputs.
// [R16] Each linked stage adds its own delay; latencies sum.
// [R17] Feedback must close within 150 ms after output falls.
// [R18] Flash and pause durations are cycle-count constants.
`timescale 1ns/10ps
`include "srf_map.vh"
module srf_indicator #(
   parameter [31:0] SUPPLY_LOSS_CYC = `SRF_SUPPLY_LOSS_MS * `SRF_CLK_KHZ,
   parameter [31:0] OFF_MIN_CYC = `SRF_OFF_MIN_MS * `SRF_CLK_KHZ,
   parameter [31:0] FB_TIMEOUT_CYC = `SRF_FB_TIMEOUT_MS * `SRF_CLK_KHZ,
   parameter [31:0] FLASH_CYC = `SRF_FLASH_MS * `SRF_CLK_KHZ,
   parameter [31:0] SHORT_CYC = `SRF_SHORT_MS * `SRF_CLK_KHZ,
   parameter [31:0] PAUSE_CYC = `SRF_LEAD_PAUSE_MS * `SRF_CLK_KHZ,
   parameter [31:0] BLINK_CYC = `SRF_BLINK_MS * `SRF_CLK_KHZ,
   parameter [31:0] TEST_CYC = `SRF_TEST_PERIOD_MS * `SRF_CLK_KHZ,
   parameter [31:0] INIT_CYC = `SRF_INIT_MS * `SRF_CLK_KHZ
) (
   // Clock and power-up reset
   input wire clk_sys,
   input wire rst,
   // Pins from the field
   input wire supply_ok,
   input wire and_link_input,
   input wire feedback_14,
   input wire feedback_24,
   input wire mode_pin,
   // From input circuit evaluation
   input wire enable_14,
   input wire enable_24,
   input wire start_pending,
   input wire one_channel_open,
   input wire ext_fault,
   input wire [`SRF_CODE_W-1:0] ext_code,
   input wire [`SRF_NDIG_W-1:0] ext_ndig,
   // Safety outputs and state
   output reg out_14,
   output reg out_24,
   output reg ready,
   output reg mode_latched,
   output reg locked,
   // LEDs
   output reg power_led,
   output reg first_channel_led,
   output reg second_channel_led
);
   localparam [1:0] PH_INIT = 2'h0;
   localparam [1:0] PH_RUN = 2'h1;
   localparam [1:0] PH_LOCK = 2'h2;
   // Two-flop synchronisers for field pins
   reg [4:0] sync_a;
   reg [4:0] sync_b;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
      end else begin
         sync_a <= {mode_pin, feedback_24, feedback_14, and_link_input,
                    supply_ok};
         sync_b <= sync_a;
      end
   end
   wire sup = sync_b[0];
   // Link pin sync delay adds to the latency of each linked stage
   wire link = sync_b[1]; // [R16]
   wire fb14 = sync_b[2];
   wire fb24 = sync_b[3];
   wire mode_s = sync_b[4];

   reg [1:0] phase;
   reg [31:0] init_tmr;
   reg [31:0] loss_tmr;
   reg [31:0] off_tmr;
   reg [31:0] fb_tmr;
   reg [31:0] blink_tmr;
   reg [31:0] test_tmr;
   reg blink;
   reg fb_armed;
   reg fb_fault;
   reg sup_fault;
   reg en14_q;
   reg en24_q;

   function [31:0] dec;
      input [31:0] v;
      begin
         dec = (v == 32'h0000_0000) ? v : v - 32'h0000_0001;
      end
   endfunction

   // Gated enables: link low forces outputs low
   wire run = (phase == PH_RUN);
   wire g14 = run & link & enable_14 & ~fb_fault; // [R13]
   wire g24 = run & link & enable_24 & ~fb_fault; // [R13]
   // On-state: an output switches on only with its feedback loop closed
   wire on14 = g14 & (fb14 | en14_q); // [R5]
   wire on24 = g24 & (fb24 | en24_q); // [R5]
   wire start_fb_open = (g14 & ~en14_q & ~fb14) | (g24 & ~en24_q & ~fb24);
   wire pulse_low = (test_tmr < `SRF_TEST_LOW_CYC);
   wire fault_on = fb_fault | sup_fault | ext_fault;
   wire [`SRF_CODE_W-1:0] code = sup_fault ? `SRF_CODE_SUP :
      (fb_fault ? `SRF_CODE_FB : ext_code);
   wire [`SRF_NDIG_W-1:0] ndig = sup_fault ? `SRF_NDIG_SUP :
      (fb_fault ? `SRF_NDIG_FB : ext_ndig);
   wire code_lamp;

   srf_flash #(
      .SHORT_CYC(SHORT_CYC),
      .FLASH_CYC(FLASH_CYC),
      .PAUSE_CYC(PAUSE_CYC)
   ) u_flash (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(fault_on), // [R18]
      .code(code),
      .ndig(ndig),
      .lamp(code_lamp)
   );

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase <= PH_INIT;
         init_tmr <= 32'h0000_0000;
         loss_tmr <= 32'h0000_0000;
         off_tmr <= 32'h0000_0000;
         fb_tmr <= 32'h0000_0000;
         blink_tmr <= 32'h0000_0000;
         test_tmr <= 32'h0000_0000;
         blink <= 1'b0;
         fb_armed <= 1'b0;
         fb_fault <= 1'b0;
         sup_fault <= 1'b0;
         en14_q <= 1'b0;
         en24_q <= 1'b0;
         ready <= 1'b0;
         mode_latched <= 1'b0;
         locked <= 1'b0;
         out_14 <= 1'b0;
         out_24 <= 1'b0;
         power_led <= 1'b0;
         first_channel_led <= 1'b0;
         second_channel_led <= 1'b0;
      end else begin
         blink_tmr <= dec(blink_tmr);
         if (blink_tmr == 32'h0000_0000) begin
            blink_tmr <= BLINK_CYC;
            blink <= ~blink;
         end
         test_tmr <= (test_tmr == 32'h0000_0000) ? TEST_CYC : dec(test_tmr);
         // Off time counts from the supply loss itself, saturating at limit
         off_tmr <= sup ? 32'h0000_0000 :
            (off_tmr == OFF_MIN_CYC) ? off_tmr : off_tmr + 32'h0000_0001;
         case (phase)
            PH_INIT: begin
               mode_latched <= mode_s; // [R2]
               init_tmr <= init_tmr + 32'h0000_0001;
               if (sup && init_tmr >= INIT_CYC) begin
                  phase <= PH_RUN;
                  ready <= 1'b1;
               end
            end
            PH_RUN: begin
               // Supply gap longer than limit locks out
               loss_tmr <= sup ? 32'h0000_0000 : loss_tmr + 32'h0000_0001;
               if (!sup && loss_tmr >= SUPPLY_LOSS_CYC) begin // [R6]
                  phase <= PH_LOCK;
                  sup_fault <= 1'b1;
                  ready <= 1'b0;
                  locked <= 1'b1;
               end
            end
            PH_LOCK: begin
               // Leave only after supply off for the minimum time
               if (sup && off_tmr >= OFF_MIN_CYC) begin // [R7]
                  phase <= PH_INIT;
                  init_tmr <= 32'h0000_0000;
                  sup_fault <= 1'b0;
                  fb_fault <= 1'b0;
                  locked <= 1'b0;
               end
            end
            default: phase <= PH_INIT;
         endcase
         // Feedback must close after an output falls
         en14_q <= on14;
         en24_q <= on24;
         if ((en14_q & ~on14) | (en24_q & ~on24)) begin
            fb_armed <= 1'b1;
            fb_tmr <= FB_TIMEOUT_CYC;
         end else if (fb_armed) begin
            fb_tmr <= dec(fb_tmr);
            if (fb14 & fb24)
               fb_armed <= 1'b0;
            else if (fb_tmr == 32'h0000_0000) begin // [R17]
               fb_armed <= 1'b0;
               fb_fault <= 1'b1;
            end
         end
         // Outputs carry test pulses while high
         out_14 <= on14 & ~pulse_low; // [R12]
         out_24 <= on24 & ~pulse_low; // [R12]
         power_led <= (run && !start_pending) ? 1'b1 : blink; // [R1] [R4]
         if (fault_on) begin
            first_channel_led <= code_lamp; // [R8]
            second_channel_led <= 1'b0;
         end else if (start_fb_open | one_channel_open) begin
            first_channel_led <= blink; // [R5]
            second_channel_led <= ~blink; // [R5]
         end else begin
            // Steady high with pulses hidden from the LED
            first_channel_led <= on14; // [R3]
            second_channel_led <= on24; // [R3]
         end
      end
   end
endmodule // srf_indicator

// ==== testbench/srf_props.sv ====
// Checker for srf_indicator: output gating, LED links, test pulses.
// Assumes a bind onto srf_indicator; sees only its ports.
`timescale 1ns/10ps
module srf_props #(
   parameter [31:0] TEST_CYC = 32'h0000_01F4
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Inputs
   input wire and_link_input,
   input wire enable_14,
   input wire enable_24,
   input wire start_pending,
   input wire one_channel_open,
   // Outputs
   input wire out_14,
   input wire out_24,
   input wire ready,
   input wire mode_latched,
   input wire locked,
   input wire power_led,
   input wire first_channel_led,
   input wire second_channel_led
);
   reg [31:0] hi_cnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Unbroken high run of output 14; a stuck-high output runs it past TEST_CYC + 2
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         hi_cnt <= 32'h0000_0000;
      else
         hi_cnt <= out_14 ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
   end
   a_enable_gate: assert property (!enable_14 |=> !out_14)
      else $error("output 14 high without enable");
   a_link_gate: assert property (!and_link_input [*3] |=>
      !out_14 && !out_24) else $error("outputs high with link low");
   a_rise_cause: assert property ($rose(out_24) |-> $past(enable_24))
      else $error("output 24 rose without enable");
   a_led_first: assert property (out_14 && !one_channel_open &&
      !$past(one_channel_open) |-> first_channel_led)
      else $error("first LED dark while output 14 high");
   a_led_second: assert property (out_24 && !one_channel_open &&
      !$past(one_channel_open) |-> second_channel_led)
      else $error("second LED dark while output 24 high");
   a_ready_gate: assert property (!ready && !$past(ready) |->
      !out_14 && !out_24) else $error("outputs high before ready");
   a_lock_gate: assert property (locked && $past(locked) |->
      !out_14 && !out_24) else $error("outputs high while locked");
   a_mode_hold: assert property (ready && $past(ready) |->
      $stable(mode_latched)) else $error("mode changed in run");
   a_power_steady: assert property ((ready && !start_pending &&
      !locked) [*2] |-> power_led) else $error("power LED not steady");
   a_pulse_due: assert property (hi_cnt <= TEST_CYC + 2)
      else $error("no test pulse on output 14");
   c_on: cover property ($rose(out_14));
   c_lock: cover property ($rose(locked));
   c_code: cover property (locked && first_channel_led);
endmodule // srf_props
bind srf_indicator srf_props #(.TEST_CYC(TEST_CYC)) chk (
   .clk_sys(clk_sys), .rst(rst), .and_link_input(and_link_input),
   .enable_14(enable_14), .enable_24(enable_24),
   .start_pending(start_pending), .one_channel_open(one_channel_open),
   .out_14(out_14), .out_24(out_24), .ready(ready),
   .mode_latched(mode_latched), .locked(locked), .power_led(power_led),
   .first_channel_led(first_channel_led),
   .second_channel_led(second_channel_led));

// ==== testbench/srf_contactor.sv ====
// Contactor model closing the feedback loop of one safety output.
// Assumes feedback closed reads high; weld holds the contact open.
`timescale 1ns/10ps
module srf_contactor #(
   parameter [31:0] HOLD = 32'h0000_0078
) (
   input wire clk_sys,
   input wire coil,
   input wire weld,
   output reg fb
);
   reg [31:0] low_cnt;
   initial begin
      low_cnt = HOLD;
      fb = 1'b1;
   end
   // Armature ignores short test pulses: releases only after HOLD cycles
   always @(posedge clk_sys) begin
      if (coil)
         low_cnt <= 32'h0000_0000;
      else if (low_cnt < HOLD)
         low_cnt <= low_cnt + 32'h0000_0001;
      fb <= !coil && low_cnt >= HOLD && !weld;
   end
endmodule // srf_contactor

// ==== testbench/tb.sv ====
// Self-checking bench for srf_indicator with shortened durations.
// Assumes srf_contactor closes the feedback loops of both outputs.
`timescale 1ns/10ps
module tb;
   localparam [31:0] SL = 32'h0000_0028;
   localparam [31:0] OM = 32'h0000_03E8;
   localparam [31:0] FL = 32'h0000_0014;
   localparam [31:0] SH = 32'h0000_0008;
   localparam [31:0] BL = 32'h0000_000A;
   localparam [31:0] IN = 32'h0000_0032;
   reg clk_sys = 1'b0, rst = 1'b1, supply_ok = 1'b1, and_link_input = 1'b1;
   reg mode_pin = 1'b1, enable_14 = 1'b0, enable_24 = 1'b0, weld = 1'b0;
   reg start_pending = 1'b0, one_channel_open = 1'b0, ext_fault = 1'b0;
   reg [15:0] ext_code = 16'h0000;
   reg [2:0] ext_ndig = 3'h1;
   wire fb_14, fb_24, out_14, out_24, ready, mode_latched, locked;
   wire power_led, first_channel_led, second_channel_led;
   int bad_count = 0, tests_run = 0, cycles = 0;
   srf_indicator #(.SUPPLY_LOSS_CYC(SL), .OFF_MIN_CYC(OM),
      .FB_TIMEOUT_CYC(32'h0000_012C), .FLASH_CYC(FL), .SHORT_CYC(SH),
      .PAUSE_CYC(32'h0000_0028), .BLINK_CYC(BL), .TEST_CYC(32'h0000_01F4),
      .INIT_CYC(IN)) dut (.clk_sys(clk_sys), .rst(rst),
      .supply_ok(supply_ok), .and_link_input(and_link_input),
      .feedback_14(fb_14), .feedback_24(fb_24), .mode_pin(mode_pin),
      .enable_14(enable_14), .enable_24(enable_24),
      .start_pending(start_pending), .one_channel_open(one_channel_open),
      .ext_fault(ext_fault), .ext_code(ext_code), .ext_ndig(ext_ndig),
      .out_14(out_14), .out_24(out_24), .ready(ready),
      .mode_latched(mode_latched), .locked(locked), .power_led(power_led),
      .first_channel_led(first_channel_led),
      .second_channel_led(second_channel_led));
   srf_contactor k14 (.clk_sys(clk_sys), .coil(out_14), .weld(weld),
      .fb(fb_14));
   srf_contactor k24 (.clk_sys(clk_sys), .coil(out_24), .weld(1'b0),
      .fb(fb_24));
   always #5 clk_sys = ~clk_sys;
   task finish_test;
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task check_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t bit %b want %b", $time, got, exp);
      end
   endtask
   task check_num(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         bad_count++;
         $display("MISMATCH %0t width %0d want %0d", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task look(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task watch(input int n, output int p1, output int f1, output int df);
      p1 = 0;
      f1 = 0;
      df = 0;
      repeat (n) begin
         look(1);
         p1 += (power_led === 1'b1);
         f1 += (first_channel_led === 1'b1);
         df += (first_channel_led !== second_channel_led);
      end
   endtask
   task get_width(output int w);
      int n;
      n = 0;
      w = 0;
      while (first_channel_led !== 1'b1 && n < 5000) begin
         look(1);
         n++;
      end
      while (first_channel_led === 1'b1) begin
         look(1);
         w++;
      end
   endtask
   // One full sequence from the first short flash; digits as flash counts
   task check_code(input int n1, input int n2);
      int w, i;
      for (i = 0; i < 3 + n1 + n2; i++) begin
         get_width(w);
         check_num(w, i < 3 ? SH : FL);
      end
   endtask
   task wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < IN + 50) begin
         look(1);
         n++;
      end
   endtask
   task power_cycle(input logic m);
      cyc(1);
      supply_ok <= 1'b0;
      mode_pin <= m;
      cyc(OM + 10);
      supply_ok <= 1'b1;
      wait_ready;
      check_bit(locked, 1'b0);
      check_bit(mode_latched, m);
   endtask
   task t_init;
      int p1, f1, df;
      watch(IN / 2, p1, f1, df);
      check_bit(ready, 1'b0);
      check_bit(p1 > 0 && p1 < IN / 2, 1'b1);
      wait_ready;
      look(3);
      watch(3 * BL, p1, f1, df);
      check_bit(p1 == 3 * BL, 1'b1);
      check_bit(mode_latched, 1'b1);
   endtask
   task t_outputs;
      int p1, f1, df, lo;
      cyc(1);
      enable_14 <= 1'b1;
      enable_24 <= 1'b1;
      look(4);
      check_bit(out_24, 1'b1);
      check_bit(second_channel_led, 1'b1);
      lo = 0;
      f1 = 0;
      repeat (700) begin
         look(1);
         lo += (out_14 === 1'b0);
         f1 += (first_channel_led === 1'b1);
      end
      // Test pulses are 100 cycles low; one or two fit in 700 cycles
      check_bit(lo >= 100 && lo <= 200, 1'b1);
      check_bit(f1 == 700, 1'b1);
      cyc(1);
      and_link_input <= 1'b0;
      look(4);
      check_bit(out_14 | out_24, 1'b0);
      // Let the contactors drop out so both loops are closed on return
      cyc(140);
      and_link_input <= 1'b1;
      enable_24 <= 1'b0;
      look(5);
      check_bit(second_channel_led, 1'b0);
      check_bit(first_channel_led, 1'b1);
      cyc(1);
      enable_14 <= 1'b0;
      start_pending <= 1'b1;
      one_channel_open <= 1'b1;
      look(4);
      watch(4 * BL, p1, f1, df);
      check_bit(p1 > 0 && p1 < 4 * BL, 1'b1);
      check_bit(f1 > 0 && df >= 4 * BL - 2, 1'b1);
      cyc(1);
      start_pending <= 1'b0;
      one_channel_open <= 1'b0;
   endtask
   task t_fb;
      int p1, f1, df;
      cyc(200);
      weld <= 1'b1;
      cyc(4);
      enable_14 <= 1'b1;
      look(4);
      watch(4 * BL, p1, f1, df);
      check_bit(out_14, 1'b0);
      check_bit(df == 4 * BL, 1'b1);
      cyc(1);
      weld <= 1'b0;
      look(8);
      check_bit(first_channel_led, 1'b1);
      cyc(1);
      weld <= 1'b1;
      enable_14 <= 1'b0;
      look(4);
      check_code(1, 8);
      check_code(1, 8);
      cyc(1);
      weld <= 1'b0;
      enable_14 <= 1'b1;
      look(200);
      check_bit(out_14, 1'b0);
      cyc(1);
      enable_14 <= 1'b0;
      power_cycle(1'b1);
   endtask
   task t_supply;
      cyc(200);
      enable_24 <= 1'b1;
      supply_ok <= 1'b0;
      cyc(SL / 2);
      supply_ok <= 1'b1;
      look(6);
      check_bit(second_channel_led, 1'b1);
      cyc(1);
      enable_24 <= 1'b0;
      cyc(200);
      supply_ok <= 1'b0;
      check_code(8, 2);
      check_bit(locked, 1'b1);
      cyc(1);
      supply_ok <= 1'b1;
      look(IN + 20);
      check_bit(locked, 1'b1);
      power_cycle(1'b0);
   endtask
   task t_zero;
      cyc(1);
      ext_code <= 16'h0010;
      ext_ndig <= 3'h2;
      ext_fault <= 1'b1;
      check_code(1, 16);
      cyc(1);
      ext_fault <= 1'b0;
      power_cycle(1'b1);
   endtask
   initial begin
      cyc(8);
      rst <= 1'b0;
      t_init;
      t_outputs;
      t_fb;
      t_supply;
      t_zero;
      finish_test;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         finish_test;
      end
   end
endmodule // tb
